// ---- logic/lqd_top.v ----
// link queue control, memory window decode and register slave
`timescale 1ns/1ns
`default_nettype none
`include "lqd_map.vh"
module lqd_top (
    input wire aclk,
    input wire aresetn,
    input wire [9:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [9:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire req_valid,
    input wire [35:0] req_addr,
    input wire req_write,
    input wire req_from_pci,
    output reg route_valid,
    output reg route_to_pci,
    output reg route_refused,
    output reg [3:0] link_weight,
    output reg dual_addr_ok,
    output reg [3:0] burst_max_quadword,
    output reg order_relaxed,
    output reg [1:0] fc_threshold
);
    reg [7:0] lqc2_reg;
    reg [15:0] top_reg;
    reg [15:0] hole1_reg;
    reg [15:0] hole2_reg;
    reg [15:0] srd_reg;
    reg [15:0] swr_reg;
    reg [9:0] awaddr_reg;
    reg aw_have_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg w_have_reg;
    reg [2:0] hits_reg;
    wire hit1;
    wire hit2;
    wire above_top;
    wire in_f;
    wire in_ec;
    wire shadow_area;
    wire to_pci;
    wire refuse;
    wire [7:0] widx;
    wire [7:0] ridx;
    wire wr_go;
    reg [31:0] rd_word;
    reg rd_ok;
    reg [1:0] wstate_reg;
    reg [1:0] wstate_next;
    reg [1:0] rstate_reg;
    reg [1:0] rstate_next;
    reg wr_known;
    wire rd_go;
    wire route_pci_next;
    wire route_refuse_next;
    reg [3:0] weight_next;
    reg [3:0] burst_next;

    // one-hot channel states: collecting a request, or holding an answer
    localparam [1:0] WS_TAKE = 2'b01;
    localparam [1:0] WS_RESP = 2'b10;
    localparam [1:0] RS_TAKE = 2'b01;
    localparam [1:0] RS_ANSWER = 2'b10;

    // window compares, one instance each
    lqd_hole_win u_hole1 (
        .win(hole1_reg),
        .enable(swr_reg[`LQD_F_HOLE1_EN]),
        .addr(req_addr),
        .hit(hit1)
    );
    lqd_hole_win u_hole2 (
        .win(hole2_reg),
        .enable(swr_reg[`LQD_F_HOLE2_EN]),
        .addr(req_addr),
        .hit(hit2)
    );

    // top bound compares A[35:23]; bit 0 switches the bound off
    lqd_hole_match u_top_bound (
        .bound(top_reg),
        .addr(req_addr),
        .above(above_top)
    );
    assign in_f = (req_addr[35:16] == 20'h0000f);
    assign in_ec = (req_addr[35:14] == 22'h00003b);
    assign shadow_area = in_f || in_ec;
    // only the read attribute is modelled; shadow writes go by memory
    assign to_pci = hit1 || hit2 || above_top ||
        (!req_write && in_f && !srd_reg[`LQD_F_RD_F]) ||
        (!req_write && in_ec && !srd_reg[`LQD_F_RD_EC]);
    // a PCI master may not touch shadow while disabled
    assign refuse = req_from_pci && shadow_area && !srd_reg[`LQD_F_SH_EN];
    // dual-address cycles are refused above 4G when disabled
    wire dac_block;
    assign dac_block = lqc2_reg[`LQD_F_DAC_DIS] && (req_addr[35:32] != 4'h0);
    // a refused access never also claims the PCI path
    assign route_refuse_next = refuse || dac_block;
    assign route_pci_next = to_pci && !route_refuse_next;

    // route decision registered so outputs leave flip-flops
    always @(posedge aclk) begin
        if (!aresetn) begin
            route_valid <= 1'b0;
            route_to_pci <= 1'b0;
            route_refused <= 1'b0;
        end else begin
            route_valid <= req_valid;
            route_to_pci <= req_valid && route_pci_next;
            route_refused <= req_valid && route_refuse_next;
        end
    end

    // hit flags of the last request, kept for the status word
    always @(posedge aclk) begin
        if (!aresetn) begin
            hits_reg <= 3'h0;
        end else if (req_valid) begin
            hits_reg <= {above_top, hit2, hit1};
        end
    end

    // arbitration weight code to multiplier: 1x, 2x, 4x, 8x
    always @* begin
        case (lqc2_reg[`LQD_F_WEIGHT_HI:`LQD_F_WEIGHT_LO])
            2'h0: weight_next = 4'h1;
            2'h1: weight_next = 4'h2;
            2'h2: weight_next = 4'h4;
            2'h3: weight_next = 4'h8;
            default: weight_next = 4'h1;
        endcase
    end

    // length limit picks the short burst; the long one is the default
    always @* begin
        if (lqc2_reg[`LQD_F_LEN4]) begin
            burst_next = `LQD_QW_SHORT;
        end else begin
            burst_next = `LQD_QW_LONG;
        end
    end

    // control fields presented to the link arbiter and queues
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_weight <= 4'h1;
            dual_addr_ok <= 1'b1;
            burst_max_quadword <= `LQD_QW_LONG;
            order_relaxed <= 1'b0;
            fc_threshold <= 2'h0;
        end else begin
            link_weight <= weight_next;
            dual_addr_ok <= !lqc2_reg[`LQD_F_DAC_DIS];
            burst_max_quadword <= burst_next;
            order_relaxed <= lqc2_reg[`LQD_F_RELAX];
            fc_threshold <= lqc2_reg[`LQD_F_FC_HI:`LQD_F_FC_LO];
        end
    end

    // write channel: address and data caught in either order
    assign wr_go = (wstate_reg == WS_TAKE) && aw_have_reg && w_have_reg;
    assign widx = awaddr_reg[9:2];

    // writable indices answer okay; status and unmapped indices answer slverr
    always @* begin
        case (widx)
            `LQD_IDX_LQC2: wr_known = 1'b1;
            `LQD_IDX_TOP: wr_known = 1'b1;
            `LQD_IDX_HOLE1: wr_known = 1'b1;
            `LQD_IDX_HOLE2: wr_known = 1'b1;
            `LQD_IDX_SRD: wr_known = 1'b1;
            `LQD_IDX_SWR: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    // response stands until bready, so no half is taken while it is up
    always @* begin
        wstate_next = wstate_reg;
        case (wstate_reg)
            WS_TAKE: begin
                if (aw_have_reg && w_have_reg) begin
                    wstate_next = WS_RESP;
                end
            end
            WS_RESP: begin
                if (s_axi_bready) begin
                    wstate_next = WS_TAKE;
                end
            end
            default: wstate_next = WS_TAKE;
        endcase
    end

    // ready pulses every other idle cycle; a master holding valid still meets it
    always @(posedge aclk) begin
        if (!aresetn) begin
            wstate_reg <= WS_TAKE;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= 10'h000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            wstate_reg <= wstate_next;
            s_axi_awready <= !aw_have_reg && !s_axi_awready && (wstate_reg == WS_TAKE);
            s_axi_wready <= !w_have_reg && !s_axi_wready && (wstate_reg == WS_TAKE);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
            end else if ((wstate_reg == WS_RESP) && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register file; byte lanes honoured, status word is read only
    always @(posedge aclk) begin
        if (!aresetn) begin
            lqc2_reg <= `LQD_RST_LQC2;
            top_reg <= `LQD_RST_16;
            hole1_reg <= `LQD_RST_16;
            hole2_reg <= `LQD_RST_16;
            srd_reg <= `LQD_RST_16;
            swr_reg <= `LQD_RST_16;
        end else if (wr_go) begin
            if (widx == `LQD_IDX_LQC2 && wstrb_reg[0]) begin
                lqc2_reg <= wdata_reg[7:0];
            end
            if (widx == `LQD_IDX_TOP) begin
                if (wstrb_reg[0]) top_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) top_reg[15:8] <= wdata_reg[15:8];
            end
            if (widx == `LQD_IDX_HOLE1) begin
                if (wstrb_reg[0]) hole1_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) hole1_reg[15:8] <= wdata_reg[15:8];
            end
            if (widx == `LQD_IDX_HOLE2) begin
                if (wstrb_reg[0]) hole2_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) hole2_reg[15:8] <= wdata_reg[15:8];
            end
            if (widx == `LQD_IDX_SRD) begin
                if (wstrb_reg[0]) srd_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) srd_reg[15:8] <= wdata_reg[15:8];
            end
            if (widx == `LQD_IDX_SWR) begin
                if (wstrb_reg[0]) swr_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) swr_reg[15:8] <= wdata_reg[15:8];
            end
        end
    end

    // read decode; unmapped index answers slverr with zero data
    assign ridx = s_axi_araddr[9:2];
    always @* begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        case (ridx)
            `LQD_IDX_LQC2: rd_word = {24'h000000, lqc2_reg};
            `LQD_IDX_TOP: rd_word = {16'h0000, top_reg};
            `LQD_IDX_HOLE1: rd_word = {16'h0000, hole1_reg};
            `LQD_IDX_HOLE2: rd_word = {16'h0000, hole2_reg};
            `LQD_IDX_SRD: rd_word = {16'h0000, srd_reg};
            `LQD_IDX_SWR: rd_word = {16'h0000, swr_reg};
            `LQD_IDX_STAT: rd_word = {29'h00000000, hits_reg};
            default: rd_ok = 1'b0;
        endcase
    end

    // read channel: one read at a time, data one cycle after acceptance
    assign rd_go = (rstate_reg == RS_TAKE) && s_axi_arvalid && s_axi_arready;

    // answer stands until rready; arready is held low while it is up
    always @* begin
        rstate_next = rstate_reg;
        case (rstate_reg)
            RS_TAKE: begin
                if (rd_go) begin
                    rstate_next = RS_ANSWER;
                end
            end
            RS_ANSWER: begin
                if (s_axi_rready) begin
                    rstate_next = RS_TAKE;
                end
            end
            default: rstate_next = RS_TAKE;
        endcase
    end

    // read address and answer registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            rstate_reg <= RS_TAKE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            rstate_reg <= rstate_next;
            s_axi_arready <= !s_axi_arready && (rstate_reg == RS_TAKE);
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
            end else if ((rstate_reg == RS_ANSWER) && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- logic/lqd_map.vh ----
// register offsets, field positions, reset values and decode constants for the link decode block
// Notes on behaviour
// - arbitration weight 1x/2x/4x/8x from two bits
// - dual-address disable limits addressing below 4G
// - burst length eight quadwords, or four
// - release-order bit relaxes ordering when set
// - downstream IO threshold field, resets immediate
// - top bound compares A[35:23], bit0 disables
// - window one size code 64KB doubling to 8MB
// - window one base gives A[28:16]
// - window two encoded like window one
// - PCI masters reach shadow only when enabled
// - F0000-FFFFF reads from memory if bit12
// - EC000-EFFFF reads from memory if bit11
// - each window needs its own enable bit
`ifndef LQD_MAP_VH
`define LQD_MAP_VH
// printed offsets are not all word multiples, so they are indices
`define LQD_IDX_LQC2 8'hc1
`define LQD_IDX_TOP 8'hc2
`define LQD_IDX_HOLE1 8'hc4
`define LQD_IDX_HOLE2 8'hc6
`define LQD_IDX_SRD 8'hc8
`define LQD_IDX_SWR 8'hca
`define LQD_IDX_STAT 8'hcc
`define LQD_RST_LQC2 8'h00
`define LQD_RST_16 16'h0000
// link queue control two fields
`define LQD_F_WEIGHT_HI 7
`define LQD_F_WEIGHT_LO 6
`define LQD_F_DAC_DIS 5
`define LQD_F_LEN4 4
`define LQD_F_RELAX 2
`define LQD_F_FC_HI 1
`define LQD_F_FC_LO 0
// window and shadow fields
`define LQD_F_SIZE_HI 15
`define LQD_F_SIZE_LO 13
`define LQD_F_BASE_HI 12
`define LQD_F_TOP_HI 15
`define LQD_F_TOP_LO 3
`define LQD_F_NOTOP 0
`define LQD_F_SH_EN 15
`define LQD_F_RD_F 12
`define LQD_F_RD_EC 11
`define LQD_F_HOLE2_EN 15
`define LQD_F_HOLE1_EN 14
// burst caps in quadwords
`define LQD_QW_LONG 4'h8
`define LQD_QW_SHORT 4'h4
`endif

// ---- logic/lqd_hole_match.v ----
// top-of-memory compare: addresses at or above the bound fall through to PCI
`timescale 1ns/1ns
`default_nettype none
`include "lqd_map.vh"
module lqd_hole_match (
    input wire [15:0] bound,
    input wire [35:0] addr,
    output wire above
);
    wire [12:0] limit;
    // bound field holds A[35:23]; a set bit 0 removes the limit altogether
    assign limit = bound[`LQD_F_TOP_HI:`LQD_F_TOP_LO];
    assign above = !bound[`LQD_F_NOTOP] && (addr[35:23] >= limit);
endmodule
`default_nettype wire

// ---- logic/lqd_hole_win.v ----
// one hole window compare: size code and base against a memory address
`timescale 1ns/1ns
`default_nettype none
`include "lqd_map.vh"
module lqd_hole_win (
    input wire [15:0] win,
    input wire enable,
    input wire [35:0] addr,
    output wire hit
);
    wire [2:0] size_code;
    wire [12:0] mask;
    // size code n covers 2^n blocks of 64KB; low n base bits are ignored
    assign size_code = win[`LQD_F_SIZE_HI:`LQD_F_SIZE_LO];
    assign mask = 13'h1fff << size_code;
    // window sits in the low 512 Mbytes, so A[35:29] must be zero
    assign hit = enable && (addr[35:29] == 7'h00) &&
        ((addr[28:16] & mask) == (win[`LQD_F_BASE_HI:0] & mask));
endmodule
`default_nettype wire

// ---- dv/lqd_props.sv ----
// port assertions for the link decode block
`timescale 1ns/1ns
`default_nettype none
module lqd_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic req_valid,
    input wire logic [35:0] req_addr,
    input wire logic req_from_pci,
    input wire logic route_valid,
    input wire logic route_refused,
    input wire logic [3:0] link_weight,
    input wire logic dual_addr_ok,
    input wire logic [3:0] burst_max_quadword
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_ROUTE_PULSE: assert property (req_valid |=> route_valid)
        else $error("route_valid missed a request");
    AST_ROUTE_IDLE: assert property (!req_valid |=> !route_valid)
        else $error("route_valid without a request");
    AST_WEIGHT_ONEHOT: assert property ($onehot(link_weight))
        else $error("link_weight not a single power of two");
    AST_BURST_CAP: assert property (burst_max_quadword == 4'h8 || burst_max_quadword == 4'h4)
        else $error("burst cap neither eight nor four");
    // the control output lags its register, so it must read low on both edges
    AST_DAC_REFUSE: assert property ((req_valid && |req_addr[35:32] && !dual_addr_ok)
        ##1 !dual_addr_ok |-> route_refused)
        else $error("high address passed with dual address off");
    AST_LOW_ALLOW: assert property (req_valid && !(|req_addr[35:32]) && !req_from_pci
        |=> !route_refused)
        else $error("low address from the link refused");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    AST_WRITE_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule
`default_nettype wire

// ---- dv/lqd_link_src.sv ----
// request source standing for the far side of the link
`timescale 1ns/1ns
`default_nettype none
module lqd_link_src (
    input wire logic aclk,
    output logic req_valid,
    output logic [35:0] req_addr,
    output logic req_write,
    output logic req_from_pci
);
    initial begin
        req_valid = 1'h0;
        req_addr = 36'h0;
        req_write = 1'h0;
        req_from_pci = 1'h0;
    end
    // one beat; qualifiers inverted after so a stale value never passes
    task automatic send(input logic [35:0] a, input logic w, input logic p);
        @(posedge aclk);
        req_valid <= 1'h1;
        req_addr <= a;
        req_write <= w;
        req_from_pci <= p;
        @(posedge aclk);
        req_valid <= 1'h0;
        req_addr <= ~a;
        req_write <= ~w;
        req_from_pci <= ~p;
    endtask
endmodule
`default_nettype wire

// ---- dv/lqd_top_bench.sv ----
// bench for the link decode block: registers, control outputs, routing
`timescale 1ns/1ns
`default_nettype none
module lqd_top_bench;
    localparam logic [9:0] A_LQ = 10'h304, A_TOP = 10'h308, A_H1 = 10'h310;
    localparam logic [9:0] A_H2 = 10'h318, A_SR = 10'h320, A_EN = 10'h328;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [9:0] aw_a = 10'h0, ar_a = 10'h0;
    logic [31:0] w_d = 32'h0, r_d, rd_v;
    logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
    logic aw_r, w_r, b_v, ar_r, r_v, rv, rp, rf, relax, dok, q_v, q_w, q_p;
    logic [1:0] b_s, r_s, fc, rd_s, b_last;
    logic [3:0] wt, bq;
    logic [35:0] q_a;
    logic [9:0] regs [6] = '{A_LQ, A_TOP, A_H1, A_H2, A_SR, A_EN};
    int err_total = 0, n_compared = 0;
    always #50 aclk = ~aclk;
    lqd_link_src u_src (.aclk(aclk), .req_valid(q_v), .req_addr(q_a), .req_write(q_w),
        .req_from_pci(q_p));
    lqd_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
        .s_axi_wready(w_r), .s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
        .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .req_valid(q_v),
        .req_addr(q_a), .req_write(q_w), .req_from_pci(q_p), .route_valid(rv),
        .route_to_pci(rp), .route_refused(rf), .link_weight(wt), .dual_addr_ok(dok),
        .burst_max_quadword(bq), .order_relaxed(relax), .fc_threshold(fc));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge aclk);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'h1;
        w_v <= 1'h1;
        b_r <= 1'h1;
        do begin
            @(posedge aclk);
            if (aw_r) aw_v <= 1'h0;
            if (w_r) w_v <= 1'h0;
        end while (!b_v);
        b_last = b_s;
        b_r <= 1'h0;
    endtask
    // ready raised only after the answer, so the slave must hold it
    task automatic rd(input logic [9:0] a);
        @(posedge aclk);
        ar_a <= a;
        ar_v <= 1'h1;
        do begin
            @(posedge aclk);
            if (ar_r) ar_v <= 1'h0;
        end while (!r_v);
        r_r <= 1'h1;
        @(posedge aclk);
        rd_v = r_d;
        rd_s = r_s;
        r_r <= 1'h0;
    endtask
    task automatic route(input logic [35:0] a, input logic w, p, ep, er);
        u_src.send(a, w, p);
        #1;
        chk("route_valid", 1, rv);
        chk("route_refused", er, rf);
        if (!er) chk("route_to_pci", ep, rp);
    endtask
    task automatic t_reset;
        foreach (regs[i]) begin
            rd(regs[i]);
            chk("reset value", 0, rd_v);
            chk("read resp", 0, rd_s);
        end
        chk("link_weight", 1, wt);
        chk("burst_max", 8, bq);
        chk("fc_threshold", 0, fc);
        chk("dual_addr_ok", 1, dok);
        chk("order_relaxed", 0, relax);
        rd(10'h3fc);
        chk("unmapped resp", 2, rd_s);
        wr(A_EN, 32'h0);
        chk("write resp", 0, b_last);
        wr(10'h330, 32'h7);
        chk("status write resp", 2, b_last);
        rd(10'h330);
        chk("status after refused write", 0, rd_v);
    endtask
    task automatic t_ctrl;
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = {i[1:0], i[0], i[1], 1'h0, i[0], i[1:0]};
            wr(A_LQ, {24'h0, d});
            rd(A_LQ);
            chk("lqc2 readback", d, rd_v);
            chk("link_weight", 32'h1 << i, wt);
            chk("dual_addr_ok", !i[0], dok);
            chk("burst_max", i[1] ? 4 : 8, bq);
            chk("order_relaxed", i[0], relax);
            chk("fc_threshold", i[1:0], fc);
            route(36'h100000000, 1'h0, 1'h0, 1'h1, i[0]);
        end
        wr(A_LQ, 32'h0);
    endtask
    task automatic t_top;
        wr(A_TOP, 32'h10);
        route(36'h001000000, 1'h1, 1'h0, 1'h1, 1'h0);
        route(36'h000fffff0, 1'h1, 1'h0, 1'h0, 1'h0);
        wr(A_TOP, 32'h11);
        route(36'h001000000, 1'h1, 1'h0, 1'h0, 1'h0);
    endtask
    task automatic t_hole;
        wr(A_H1, 32'h2010);
        wr(A_H2, 32'he800);
        route(36'h00011fff0, 1'h1, 1'h0, 1'h0, 1'h0);
        wr(A_EN, 32'h4000);
        route(36'h00011fff0, 1'h1, 1'h0, 1'h1, 1'h0);
        route(36'h000120000, 1'h1, 1'h0, 1'h0, 1'h0);
        route(36'h020100000, 1'h1, 1'h0, 1'h0, 1'h0);
        route(36'h000100000, 1'h1, 1'h0, 1'h1, 1'h0);
        route(36'h0000ffff0, 1'h1, 1'h0, 1'h0, 1'h0);
        route(36'h0087ffff0, 1'h1, 1'h0, 1'h0, 1'h0);
        wr(A_EN, 32'hc000);
        route(36'h0087ffff0, 1'h1, 1'h0, 1'h1, 1'h0);
        rd(10'h330);
        chk("status hits", 32'h2, rd_v);
        route(36'h008800000, 1'h1, 1'h0, 1'h0, 1'h0);
    endtask
    task automatic t_shadow;
        route(36'h0000f0000, 1'h0, 1'h0, 1'h1, 1'h0);
        wr(A_SR, 32'h1000);
        route(36'h0000fffff, 1'h0, 1'h0, 1'h0, 1'h0);
        route(36'h0000ec000, 1'h0, 1'h0, 1'h1, 1'h0);
        wr(A_SR, 32'h0800);
        route(36'h0000f0000, 1'h0, 1'h0, 1'h1, 1'h0);
        route(36'h0000effff, 1'h0, 1'h0, 1'h0, 1'h0);
        route(36'h0000ec000, 1'h0, 1'h1, 1'h0, 1'h1);
        wr(A_SR, 32'h8800);
        route(36'h0000ec000, 1'h0, 1'h1, 1'h0, 1'h0);
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_ctrl();
        t_top();
        t_hole();
        t_shadow();
        give_verdict();
    end
    // a hung handshake would otherwise stall the run forever
    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        give_verdict();
    end
endmodule
bind lqd_top lqd_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .req_valid, .req_addr, .req_from_pci, .route_valid, .route_refused,
    .link_weight, .dual_addr_ok, .burst_max_quadword);
`default_nettype wire
